/* rtl/eep_pkg.sv */
// Constants, types and decode functions for the EEPROM program/erase controller.
// Assumes one 100 MHz clock; CPU array addresses map to APB byte address 4*index.
// How it works
// - Erased bits read one; program only clears bits.
// - Program only unprotected array bytes and config byte.
// - Nonzero erase select means erase, not program.
// - Latch captures valid array writes; later replaces earlier.
// - Latched array reads return captured data.
// - Control writes ignored after latch set until array write captured.
// - Pump refused without latch and captured write.
// - Enable starts pump; clearing stops it.
// - Erase select frozen while pump enabled.
// - Clearing enable and latch together clears enable only.
// - Self-timed mode clears enable after fixed delay.
// - Block/bulk erase clear array, never config byte.
// - Four 128-byte blocks; protected target gets no voltage.
// - Protected block unerasable; bulk needs no protection.
// - Shadow reloads config byte at reset and read.
// - Config byte programs and erases like array byte.
// - Armed region lock blocks 0x08F0-0x08FF writes.
// - Armed lock stops block/bulk erase, freezes config.
// - Erase select encodes four modes; reset clears.
// - Latch cannot clear while enable set.
// - Reset clears enable, removing voltage.
package eep_pkg;
	localparam int IDX_W = 14;
	localparam int ARR_AW = 9;
	localparam int ARR_BYTES = 512;
	localparam int BLK_LSB = 7;
	localparam int CLK_PERIOD_NS = 10;
	// Self-timed pump period, longer than the manual wait
	localparam int T_AUTO_NS = 8000;
	localparam int AUTO_CYC = (T_AUTO_NS / CLK_PERIOD_NS < 1) ? 1 : T_AUTO_NS / CLK_PERIOD_NS;
	localparam int AUTO_CW = 12;

	localparam logic [IDX_W-1:0] ARR_FIRST = 14'h0800;
	localparam logic [IDX_W-1:0] ARR_LAST = 14'h09ff;
	localparam logic [IDX_W-1:0] LOCK_FIRST = 14'h08f0;
	localparam logic [IDX_W-1:0] LOCK_LAST = 14'h08ff;
	localparam logic [IDX_W-1:0] ARRAY_CONTROL_REG_IDX = 14'h0a00;
	localparam logic [IDX_W-1:0] NV_CONFIG_BYTE_IDX = 14'h0a01;
	localparam logic [IDX_W-1:0] CONFIG_SHADOW_REG_IDX = 14'h0a02;
	localparam logic [IDX_W-1:0] STATUS_REG_IDX = 14'h0a03;

	// array_control_reg fields
	localparam int CTRL_HV = 0;
	localparam int CTRL_AUTO = 1;
	localparam int CTRL_LATCH = 2;
	localparam int CTRL_ERASE_LO = 3;
	localparam int CTRL_ERASE_HI = 4;
	// status register fields
	localparam int STAT_CAPTURED = 0;
	localparam int STAT_PUMP = 1;
	// nv_config_byte / config_shadow_reg fields
	localparam int NV_BP_LSB = 0;
	localparam int NV_BP_W = 4;
	localparam int NV_LOCK_BIT = 4;

	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [7:0] SHADOW_RST = 8'hff;
	localparam logic [7:0] NV_FACTORY = 8'hf0;

	typedef enum logic [1:0] {
		EEP_IDLE = 2'b00,
		EEP_LATCH = 2'b01,
		EEP_ARMED = 2'b11,
		EEP_HV = 2'b10
	} eep_state_e;

	typedef enum logic [1:0] {
		EEP_PROG = 2'b00,
		EEP_BYTE_ERASE = 2'b01,
		EEP_BLOCK_ERASE = 2'b10,
		EEP_BULK_ERASE = 2'b11
	} eep_mode_e;

	function automatic logic eep_is_array(input logic [IDX_W-1:0] idx);
		return (idx >= ARR_FIRST) && (idx <= ARR_LAST);
	endfunction : eep_is_array

	function automatic logic [ARR_AW-1:0] eep_off(input logic [IDX_W-1:0] idx);
		logic [IDX_W-1:0] d;
		d = idx - ARR_FIRST;
		return d[ARR_AW-1:0];
	endfunction : eep_off

	// Whether the latched target may receive voltage in the given mode
	function automatic logic eep_op_ok(input eep_mode_e mode, input logic [IDX_W-1:0] idx,
			input logic [7:0] shadow);
		logic armed;
		logic [NV_BP_W-1:0] bp;
		logic [ARR_AW-1:0] off;
		logic ok;
		armed = ~shadow[NV_LOCK_BIT];
		bp = shadow[NV_BP_LSB +: NV_BP_W];
		off = eep_off(idx);
		ok = 1'b0;
		if (idx == NV_CONFIG_BYTE_IDX) begin
			ok = !armed && !mode[1];
		end else if (eep_is_array(idx)) begin
			case (mode)
				EEP_PROG, EEP_BYTE_ERASE: ok = !bp[off[ARR_AW-1:BLK_LSB]]
					&& !(armed && idx >= LOCK_FIRST && idx <= LOCK_LAST);
				EEP_BLOCK_ERASE: ok = !bp[off[ARR_AW-1:BLK_LSB]] && !armed;
				EEP_BULK_ERASE: ok = (bp == '0) && !armed;
				default: ok = 1'b0;
			endcase
		end
		return ok;
	endfunction : eep_op_ok
endpackage : eep_pkg

/* rtl/eep_arr_if.sv */
// Carrier between the controller and the array storage.
// Assumes both ends share ref_clk.
interface eep_arr_if;
	logic [eep_pkg::ARR_AW-1:0] rd_off;
	logic [7:0] rd_data;
	logic [7:0] nv_data;
	logic op_go;
	eep_pkg::eep_mode_e op_mode;
	logic op_nv;
	logic [eep_pkg::ARR_AW-1:0] op_off;
	logic [7:0] op_data;
	modport ctrl(output rd_off, op_go, op_mode, op_nv, op_off, op_data, input rd_data, nv_data);
	modport mem(input rd_off, op_go, op_mode, op_nv, op_off, op_data, output rd_data, nv_data);
endinterface : eep_arr_if

/* rtl/eep_array.sv */
// Array storage: 512 bytes plus the nonvolatile config byte.
// Assumes op_go is a one-cycle pulse already cleared for protection.
module eep_array #(
	parameter logic [7:0] NV_INIT = eep_pkg::NV_FACTORY
) (
	// Clock
	input wire logic ref_clk,
	// Controller side
	eep_arr_if.mem bus
);
	// Contents are nonvolatile, so reset never touches them
	logic [7:0] mem_ff [0:eep_pkg::ARR_BYTES-1] = '{default: eep_pkg::ERASED};
	logic [7:0] nv_ff = NV_INIT;
	logic [7:0] exp_ff;
	logic [eep_pkg::ARR_AW-1:0] chk_off_ff;

	assign bus.rd_data = mem_ff[bus.rd_off];
	assign bus.nv_data = nv_ff;

	always_ff @(posedge ref_clk) begin
		if (bus.op_go) begin
			case (bus.op_mode)
				eep_pkg::EEP_PROG: begin
					if (bus.op_nv) nv_ff <= nv_ff & bus.op_data;
					else mem_ff[bus.op_off] <= mem_ff[bus.op_off] & bus.op_data;
				end
				eep_pkg::EEP_BYTE_ERASE: begin
					if (bus.op_nv) nv_ff <= eep_pkg::ERASED;
					else mem_ff[bus.op_off] <= eep_pkg::ERASED;
				end
				eep_pkg::EEP_BLOCK_ERASE: begin
					for (int i = 0; i < eep_pkg::ARR_BYTES; i++) begin
						if (i[eep_pkg::ARR_AW-1:eep_pkg::BLK_LSB]
								== bus.op_off[eep_pkg::ARR_AW-1:eep_pkg::BLK_LSB]) begin
							mem_ff[i] <= eep_pkg::ERASED;
						end
					end
				end
				default: begin
					for (int i = 0; i < eep_pkg::ARR_BYTES; i++) begin
						mem_ff[i] <= eep_pkg::ERASED;
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		exp_ff <= mem_ff[bus.op_off] & bus.op_data;
		chk_off_ff <= bus.op_off;
	end

	chk_program_ands: assert property (@(posedge ref_clk)
		bus.op_go && !bus.op_nv && bus.op_mode == eep_pkg::EEP_PROG
		|=> mem_ff[chk_off_ff] == exp_ff)
		else $error("program did not AND data into the byte");
endmodule : eep_array

/* rtl/eep_ctrl.sv */
// Top of the EEPROM program/erase controller with its APB register slave.
// Assumes an APB master on ref_clk; zero wait states, registered read data.
//
// The implementer's own choices: the APB interface to the registers and the address map.
module eep_ctrl #(
	parameter logic [7:0] NV_INIT = eep_pkg::NV_FACTORY
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Array status
	output logic pump_on,
	output logic [7:0] config_shadow
);
	localparam int AUTO_BOUND = eep_pkg::AUTO_CYC + 1;
	localparam logic [eep_pkg::AUTO_CW-1:0] AUTO_LAST = eep_pkg::AUTO_CW'(eep_pkg::AUTO_CYC - 1);

	eep_arr_if arr ();

	eep_array #(
		.NV_INIT(NV_INIT)
	) u_array (
		.ref_clk(ref_clk),
		.bus(arr.mem)
	);

	eep_pkg::eep_state_e state_ff;
	eep_pkg::eep_state_e nxt_state;
	eep_pkg::eep_mode_e erase_ff;
	eep_pkg::eep_mode_e nxt_erase;
	eep_pkg::eep_mode_e w_mode;
	logic auto_ff;
	logic nxt_auto;
	logic [eep_pkg::IDX_W-1:0] lat_idx_ff;
	logic [7:0] lat_data_ff;
	logic [7:0] shadow_ff;
	logic shadow_load_ff;
	logic [eep_pkg::AUTO_CW-1:0] auto_cnt_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic op_go_ff;
	eep_pkg::eep_mode_e op_mode_ff;
	logic op_nv_ff;
	logic [eep_pkg::ARR_AW-1:0] op_off_ff;
	logic [7:0] op_data_ff;

	logic [eep_pkg::IDX_W-1:0] idx;
	logic setup;
	logic wr;
	logic rd;
	logic hit_arr;
	logic hit_nv;
	logic hit_ctrl;
	logic hit_shadow;
	logic hit_status;
	logic mapped;
	logic latched;
	logic captured;
	logic hv_on;
	logic cap;
	logic ctrl_wr;
	logic auto_done;
	logic hv_fall;
	logic [31:0] rd_word;

	// Bus decode
	assign idx = paddr[15:2];
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign hit_arr = eep_pkg::eep_is_array(idx) && paddr[1:0] == 2'h0;
	assign hit_nv = idx == eep_pkg::NV_CONFIG_BYTE_IDX && paddr[1:0] == 2'h0;
	assign hit_ctrl = idx == eep_pkg::ARRAY_CONTROL_REG_IDX && paddr[1:0] == 2'h0;
	assign hit_shadow = idx == eep_pkg::CONFIG_SHADOW_REG_IDX && paddr[1:0] == 2'h0;
	assign hit_status = idx == eep_pkg::STATUS_REG_IDX && paddr[1:0] == 2'h0;
	assign mapped = hit_arr || hit_nv || hit_ctrl || hit_shadow || hit_status;

	// Latch bit, captured flag and pump enable all fall out of the state
	assign latched = state_ff != eep_pkg::EEP_IDLE;
	assign captured = state_ff == eep_pkg::EEP_ARMED || state_ff == eep_pkg::EEP_HV;
	assign hv_on = state_ff == eep_pkg::EEP_HV;

	// Captures are frozen under voltage so the target cannot move mid-operation
	assign cap = wr && (hit_arr || hit_nv)
		&& (state_ff == eep_pkg::EEP_LATCH || state_ff == eep_pkg::EEP_ARMED);
	assign ctrl_wr = wr && hit_ctrl && state_ff != eep_pkg::EEP_LATCH;
	assign auto_done = hv_on && auto_ff && auto_cnt_ff == AUTO_LAST;
	assign hv_fall = hv_on && nxt_state != eep_pkg::EEP_HV;
	assign w_mode = eep_pkg::eep_mode_e'({pwdata[eep_pkg::CTRL_ERASE_HI],
		pwdata[eep_pkg::CTRL_ERASE_LO]});

	always_comb begin
		nxt_state = state_ff;
		nxt_erase = erase_ff;
		nxt_auto = auto_ff;
		case (state_ff)
			eep_pkg::EEP_IDLE: begin
				// Enable written here is refused: nothing captured yet
				if (ctrl_wr && pwdata[eep_pkg::CTRL_LATCH]) nxt_state = eep_pkg::EEP_LATCH;
			end
			eep_pkg::EEP_LATCH: begin
				if (cap) nxt_state = eep_pkg::EEP_ARMED;
			end
			eep_pkg::EEP_ARMED: begin
				if (ctrl_wr) begin
					if (pwdata[eep_pkg::CTRL_HV]
							&& eep_pkg::eep_op_ok(w_mode, lat_idx_ff, shadow_ff)) begin
						nxt_state = eep_pkg::EEP_HV;
					end else if (!pwdata[eep_pkg::CTRL_LATCH]) begin
						nxt_state = eep_pkg::EEP_IDLE;
					end
				end
			end
			eep_pkg::EEP_HV: begin
				// Latch stays set when enable drops, even if both were written zero
				if (auto_done || (ctrl_wr && !pwdata[eep_pkg::CTRL_HV])) begin
					nxt_state = eep_pkg::EEP_ARMED;
				end
			end
			default: nxt_state = eep_pkg::EEP_IDLE;
		endcase
		if (ctrl_wr) begin
			nxt_auto = pwdata[eep_pkg::CTRL_AUTO];
			if (!hv_on) nxt_erase = w_mode;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_ff <= eep_pkg::EEP_IDLE;
			erase_ff <= eep_pkg::EEP_PROG;
			auto_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			erase_ff <= nxt_erase;
			auto_ff <= nxt_auto;
		end
	end

	// Self-timed termination counter
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !hv_on) auto_cnt_ff <= '0;
		else auto_cnt_ff <= auto_cnt_ff + 1'b1;
	end

	// Address and data capture
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lat_idx_ff <= eep_pkg::ARR_FIRST;
			lat_data_ff <= eep_pkg::ERASED;
		end else if (cap) begin
			lat_idx_ff <= idx;
			lat_data_ff <= pwdata[7:0];
		end
	end

	// Commit on voltage removal; protection is checked again in case the shadow moved
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			op_go_ff <= 1'b0;
			op_mode_ff <= eep_pkg::EEP_PROG;
			op_nv_ff <= 1'b0;
			op_off_ff <= '0;
			op_data_ff <= eep_pkg::ERASED;
		end else begin
			op_go_ff <= hv_fall && eep_pkg::eep_op_ok(erase_ff, lat_idx_ff, shadow_ff);
			op_mode_ff <= erase_ff;
			op_nv_ff <= lat_idx_ff == eep_pkg::NV_CONFIG_BYTE_IDX;
			op_off_ff <= eep_pkg::eep_off(lat_idx_ff);
			op_data_ff <= lat_data_ff;
		end
	end

	assign arr.op_go = op_go_ff;
	assign arr.op_mode = op_mode_ff;
	assign arr.op_nv = op_nv_ff;
	assign arr.op_off = op_off_ff;
	assign arr.op_data = op_data_ff;
	assign arr.rd_off = eep_pkg::eep_off(idx);

	// Shadow of the config byte: loaded the cycle after reset and on each read of it
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			shadow_ff <= eep_pkg::SHADOW_RST;
			shadow_load_ff <= 1'b1;
		end else begin
			shadow_load_ff <= 1'b0;
			if (shadow_load_ff || (rd && hit_nv)) shadow_ff <= arr.nv_data;
		end
	end

	// Read mux, sampled in the setup cycle so prdata comes from a flop
	always_comb begin
		rd_word = '0;
		if (hit_arr) begin
			rd_word[7:0] = latched ? lat_data_ff : arr.rd_data;
		end else if (hit_nv) begin
			rd_word[7:0] = arr.nv_data;
		end else if (hit_ctrl) begin
			rd_word[eep_pkg::CTRL_HV] = hv_on;
			rd_word[eep_pkg::CTRL_AUTO] = auto_ff;
			rd_word[eep_pkg::CTRL_LATCH] = latched;
			rd_word[eep_pkg::CTRL_ERASE_LO] = erase_ff[0];
			rd_word[eep_pkg::CTRL_ERASE_HI] = erase_ff[1];
		end else if (hit_shadow) begin
			rd_word[7:0] = shadow_ff;
		end else if (hit_status) begin
			rd_word[eep_pkg::STAT_CAPTURED] = captured;
			rd_word[eep_pkg::STAT_PUMP] = hv_on;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prdata_ff <= '0;
			pslverr_ff <= 1'b0;
		end else if (setup) begin
			prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
			pslverr_ff <= !mapped;
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = pslverr_ff;
	assign pump_on = hv_on;
	assign config_shadow = shadow_ff;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	chk_hv_needs_capture: assert property (
		$rose(hv_on) |-> $past(state_ff) == eep_pkg::EEP_ARMED && $past(ctrl_wr))
		else $error("pump enabled without a captured write");

	chk_hv_needs_latch: assert property (
		!latched |=> !hv_on)
		else $error("pump enabled straight from the unlatched state");

	chk_latch_held: assert property (
		hv_on |=> latched)
		else $error("latch cleared while pump enabled");

	chk_erase_frozen: assert property (
		hv_on ##1 hv_on |-> $stable(erase_ff))
		else $error("erase select changed under voltage");

	chk_ctrl_ignored: assert property (
		state_ff == eep_pkg::EEP_LATCH && wr && hit_ctrl
		|=> $stable(erase_ff) && $stable(auto_ff) && state_ff == eep_pkg::EEP_LATCH)
		else $error("control write taken before capture");

	chk_both_clear: assert property (
		hv_on && ctrl_wr && !pwdata[eep_pkg::CTRL_HV] && !pwdata[eep_pkg::CTRL_LATCH]
		|=> state_ff == eep_pkg::EEP_ARMED ##1 latched)
		else $error("clearing both bits dropped the latch");

	chk_auto_clear: assert property (
		$rose(hv_on) && auto_ff && !ctrl_wr |-> ##[1:AUTO_BOUND] !hv_on)
		else $error("self-timed mode failed to drop the enable");

	chk_latched_read: assert property (
		setup && !pwrite && hit_arr && latched |=> prdata_ff[7:0] == $past(lat_data_ff))
		else $error("latched array read returned stored data");

	chk_capture_taken: assert property (
		cap |=> lat_idx_ff == $past(idx) && lat_data_ff == $past(pwdata[7:0]))
		else $error("valid array write not captured");

	chk_protect_gate: assert property (
		$rose(hv_on) |-> eep_pkg::eep_op_ok(erase_ff, lat_idx_ff, $past(shadow_ff)))
		else $error("voltage applied to a protected target");

	chk_shadow_reload: assert property (
		rd && hit_nv |=> shadow_ff == $past(arr.nv_data))
		else $error("config read did not reload the shadow");

	chk_commit_pulse: assert property (
		op_go_ff |-> $past(hv_on) && !hv_on ##1 !op_go_ff)
		else $error("array operation outside voltage removal");

	chk_nv_block_free: assert property (
		op_go_ff && op_nv_ff |-> !op_mode_ff[1])
		else $error("block or bulk erase reached the config byte");

	chk_bulk_unprotected: assert property (
		$rose(hv_on) && erase_ff == eep_pkg::EEP_BULK_ERASE
		|-> shadow_ff[eep_pkg::NV_BP_LSB +: eep_pkg::NV_BP_W] == '0)
		else $error("bulk erase started with a block protected");

	chk_lock_region: assert property (
		$rose(hv_on) && !shadow_ff[eep_pkg::NV_LOCK_BIT]
		|-> !(lat_idx_ff >= eep_pkg::LOCK_FIRST && lat_idx_ff <= eep_pkg::LOCK_LAST))
		else $error("voltage applied inside the locked region");
endmodule : eep_ctrl

/* verif/eep_cpu_model.sv */
// APB master standing in for the CPU software on the far side of the controller.
// Assumes the slave shares ref_clk; the bench calls xfer for every access.
module eep_cpu_model (
	// Clock
	input wire logic ref_clk,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [15:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
	end

	// One transfer; ok is low if pready never came within the bound
	task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err, output logic ok);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		ok = (pready === 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released address and data lines show the inverse so a stale value is never mistaken for valid
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : eep_cpu_model

/* verif/tb.sv */
// Self-checking bench: program, erase, protection and lock sequences over APB.
// Assumes eep_ctrl with its default nv start value 8'hf0.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [13:0] CTRL = eep_pkg::ARRAY_CONTROL_REG_IDX;
	localparam logic [13:0] NV = eep_pkg::NV_CONFIG_BYTE_IDX;
	localparam logic [13:0] STAT = eep_pkg::STATUS_REG_IDX;
	logic ref_clk;
	logic sys_rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [15:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pump_on;
	logic [7:0] config_shadow;
	int errors = 0;
	int total_checks = 0;

	eep_ctrl eep_ctrl_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pump_on(pump_on),
		.config_shadow(config_shadow));
	eep_cpu_model eep_cpu_model_inst (.ref_clk(ref_clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;

	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic acc(input logic w, input logic [13:0] idx, input logic [7:0] d,
			output logic [7:0] v, output logic err);
		logic [31:0] q;
		logic ok;
		eep_cpu_model_inst.xfer(w, {idx, 2'b00}, {24'h000000, d}, q, err, ok);
		v = q[7:0];
		if (!ok) begin
			errors++;
			close_out();
		end
	endtask : acc

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		logic [7:0] v;
		logic e;
		acc(1'b1, idx, d, v, e);
	endtask : wr

	task automatic rdc(input logic [13:0] idx, input logic [7:0] exp);
		logic [7:0] v;
		logic e;
		acc(1'b0, idx, 8'h00, v, e);
		chk_byte(v, exp);
	endtask : rdc

	task automatic pump_is(input logic exp);
		@(posedge ref_clk);
		#1;
		chk_bit(pump_on, exp);
	endtask : pump_is

	// Full software sequence: select mode and latch, write target, enable, stop, unlatch
	task automatic op(input logic [1:0] m, input logic [13:0] idx, input logic [7:0] d,
			input logic au, input logic ep);
		logic [7:0] c;
		logic [7:0] v;
		logic e;
		int n;
		c = {3'b000, m, 1'b1, au, 1'b0};
		n = 0;
		wr(CTRL, c);
		wr(idx, d);
		wr(CTRL, c | 8'h01);
		pump_is(ep);
		if (au) begin
			// Software polls the enable bit over the bus, never counting cycles itself
			do begin
				acc(1'b0, CTRL, 8'h00, v, e);
				n++;
			end while (v[eep_pkg::CTRL_HV] !== 1'b0 && n < 2000);
			chk_bit(v[eep_pkg::CTRL_HV], 1'b0);
			chk_bit(pump_on, 1'b0);
			if (n >= 2000) close_out();
		end else begin
			wr(CTRL, c);
		end
		wr(CTRL, 8'h00);
		repeat (2) @(posedge ref_clk);
	endtask : op

	initial begin
		sys_rst = 1'b1;
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		chk_byte(config_shadow, 8'hf0);
		chk_bit(pump_on, 1'b0);
		rdc(CTRL, 8'h00);
		rdc(14'h0800, 8'hff);
		wr(CTRL, 8'h04);
		wr(CTRL, 8'h0c);
		rdc(CTRL, 8'h04);
		wr(14'h0801, 8'h3c);
		wr(14'h0802, 8'h5a);
		rdc(14'h0900, 8'h5a);
		rdc(STAT, 8'h01);
		wr(CTRL, 8'h05);
		pump_is(1'b1);
		rdc(STAT, 8'h03);
		wr(CTRL, 8'h0d);
		wr(CTRL, 8'h01);
		rdc(CTRL, 8'h05);
		wr(CTRL, 8'h00);
		rdc(CTRL, 8'h04);
		chk_bit(pump_on, 1'b0);
		wr(CTRL, 8'h00);
		rdc(14'h0802, 8'h5a);
		rdc(14'h0801, 8'hff);
		rdc(STAT, 8'h00);
		op(2'b00, 14'h0802, 8'ha5, 1'b0, 1'b1);
		rdc(14'h0802, 8'h00);
		wr(14'h0803, 8'h11);
		wr(CTRL, 8'h01);
		pump_is(1'b0);
		rdc(CTRL, 8'h00);
		op(2'b01, 14'h0802, 8'h00, 1'b1, 1'b1);
		rdc(14'h0802, 8'hff);
		op(2'b00, 14'h0850, 8'h00, 1'b0, 1'b1);
		op(2'b00, 14'h0880, 8'h00, 1'b0, 1'b1);
		op(2'b10, 14'h0810, 8'h00, 1'b0, 1'b1);
		rdc(14'h0850, 8'hff);
		rdc(14'h0880, 8'h00);
		op(2'b11, 14'h09ff, 8'h00, 1'b0, 1'b1);
		rdc(14'h0880, 8'hff);
		rdc(NV, 8'hf0);
		op(2'b01, NV, 8'h00, 1'b0, 1'b1);
		op(2'b00, NV, 8'hf1, 1'b0, 1'b1);
		chk_byte(config_shadow, 8'hf0);
		rdc(NV, 8'hf1);
		pump_is(1'b0);
		chk_byte(config_shadow, 8'hf1);
		rdc(eep_pkg::CONFIG_SHADOW_REG_IDX, 8'hf1);
		op(2'b00, 14'h0800, 8'h00, 1'b0, 1'b0);
		rdc(14'h0800, 8'hff);
		op(2'b11, 14'h0900, 8'h00, 1'b0, 1'b0);
		op(2'b10, 14'h0800, 8'h00, 1'b0, 1'b0);
		op(2'b00, 14'h0900, 8'h0f, 1'b0, 1'b1);
		op(2'b00, NV, 8'he0, 1'b0, 1'b1);
		rdc(NV, 8'he0);
		op(2'b00, 14'h08f0, 8'h00, 1'b0, 1'b0);
		rdc(14'h08f0, 8'hff);
		op(2'b01, 14'h0900, 8'h00, 1'b0, 1'b1);
		rdc(14'h0900, 8'hff);
		op(2'b10, 14'h0900, 8'h00, 1'b0, 1'b0);
		op(2'b01, NV, 8'h00, 1'b0, 1'b0);
		rdc(NV, 8'he0);
		begin : unmapped
			logic [7:0] v;
			logic e;
			acc(1'b0, 14'h0c00, 8'h00, v, e);
			chk_bit(e, 1'b1);
		end
		close_out();
	end

	// A hang ends the run through the same closing report
	initial begin
		repeat (100000) @(posedge ref_clk);
		errors++;
		close_out();
	end
endmodule : tb
